// File: pfp_fault_fsm.sv
// fault protection state machine of the pwm controller
// Notes on behaviour
// - overload held past delay turns gate off
// - overload delay timed by fast internal counter
// - overload latches gate off, counts lockout-off events
// - third lockout-off event releases overload latch
// - supply overvoltage disables gate at once
// - supply overvoltage latch clears only at power-down
// - die overtemperature gates off, auto recovers
// - low thermistor voltage latches gate off
// - thermistor latch clears at power-down under lockout
// - restart needs thermistor voltage above release level
// - current-sense sampled only after turn-off delay
// - sample above threshold flags overvoltage event
// - ten successive events turn transistor off
// - output overvoltage latched until internal reset
// - lockout off at upper, on at lower threshold
// - thermistor indication debounced before acting
`timescale 1ns/1ps
`default_nettype none
module pfp_fault_fsm #(
    parameter int unsigned OVERLOAD_CYC = pfp_pkg::OVERLOAD_DLY_CYC,
    parameter int unsigned THERM_CYC    = pfp_pkg::THERM_DEB_CYC,
    parameter int unsigned CNT_W        = 16
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          overload_in,
    input  wire logic          supply_ov_in,
    input  wire logic          die_hot_in,
    input  wire logic          therm_trip_in,
    input  wire logic          therm_release_in,
    input  wire logic          cs_ov_level_in,
    input  wire logic          gate_on_in,
    input  wire logic          vcc_above_on_in,
    input  wire logic          vcc_above_off_in,
    input  wire logic          power_down_reset_level_in,
    output logic               gate_enable_out,
    output logic               undervoltage_lockout_out,
    output pfp_pkg::pfp_state_t state_out,
    output logic               overvoltage_guard_out,
    output logic               overload_guard_out,
    output logic               therm_latch_out,
    output logic               out_ov_latch_out
);
    import pfp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for all analog comparator inputs
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic [NSYNC-1:0] raw_w;
    assign raw_w = {overload_in, supply_ov_in, die_hot_in, therm_trip_in,
                    therm_release_in, cs_ov_level_in, gate_on_in,
                    vcc_above_on_in, vcc_above_off_in,
                    power_down_reset_level_in};
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw_w;
            sync_q <= meta_q;
        end
    end
    wire ovl_s     = sync_q[9];
    wire sov_s     = sync_q[8];
    wire hot_s     = sync_q[7];
    wire trip_s    = sync_q[6];
    wire rel_s     = sync_q[5];
    wire csov_s    = sync_q[4];
    wire gate_s    = sync_q[3];
    wire von_s     = sync_q[2];
    wire voff_s    = sync_q[1];
    wire pdr_s     = sync_q[0];

    ////////////////////////////////////////////////////////////////////////
    // undervoltage lockout with hysteresis, off edge as a pulse
    logic undervoltage_lockout_q;
    logic undervoltage_lockout_d;
    logic undervoltage_lockout_off_evt;
    assign undervoltage_lockout_d = von_s ? 1'b0 : (!voff_s ? 1'b1 : undervoltage_lockout_q);
    assign undervoltage_lockout_off_evt = undervoltage_lockout_d && !undervoltage_lockout_q;
    assign undervoltage_lockout_out = undervoltage_lockout_q;

    // main state register, also read by the overload timer below
    pfp_state_t state_q;

    ////////////////////////////////////////////////////////////////////////
    // overload delay timer, cleared when indication drops
    logic ovl_done;
    // held clear outside run, so a count left from idle cannot trip at start
    wire  ovl_hold = (state_q != PFP_RUN);
    pfp_counter #(.WIDTH(CNT_W), .LIMIT(OVERLOAD_CYC)) u_ovl_cnt (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .clear_in (!ovl_s || pdr_s || ovl_hold),
        .incr_in  (ovl_s),
        .done_out (ovl_done)
    );

    // thermistor debounce timer
    logic therm_done;
    pfp_counter #(.WIDTH(CNT_W + 2), .LIMIT(THERM_CYC)) u_therm_cnt (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .clear_in (!trip_s || pdr_s),
        .incr_in  (trip_s),
        .done_out (therm_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // output overvoltage sampling after gate turn-off
    logic       gate_d1_q;
    logic [7:0] blank_q;
    logic       sampled_q;
    logic [3:0] ov_cnt_q;
    wire gate_fall = gate_d1_q && !gate_s;
    wire blank_end = (blank_q == 8'(1));
    // one sample per switching cycle, only once the ringing has settled
    wire sample_now = blank_end;
    wire ov_event   = sample_now && csov_s;
    wire ov_confirm = ov_event && (ov_cnt_q == 4'(OUT_OV_CONFIRM - 1));
    always_ff @(posedge clk_in) begin
        if (rst_in || pdr_s) begin
            gate_d1_q <= 1'b0;
            blank_q   <= '0;
            sampled_q <= 1'b0;
            ov_cnt_q  <= '0;
        end else begin
            gate_d1_q <= gate_s;
            blank_q   <= gate_fall ? 8'(SAMPLE_DLY_CYC) :
                         (blank_q != 8'(0) ? blank_q - 8'(1) : blank_q);
            sampled_q <= sample_now;
            if (ov_event && ov_cnt_q != 4'(OUT_OV_CONFIRM)) begin
                ov_cnt_q <= ov_cnt_q + 4'(1);
            end else if (sample_now && !csov_s) begin
                ov_cnt_q <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection latches
    logic sov_q;
    logic therm_q;
    logic outov_q;
    logic [1:0] undervoltage_lockout_cnt_q;
    pfp_state_t state_d;
    // thermistor latch clears only at power-down while in lockout
    wire therm_clear = pdr_s && undervoltage_lockout_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            undervoltage_lockout_q  <= 1'b1;
            sov_q   <= 1'b0;
            therm_q <= 1'b0;
            outov_q <= 1'b0;
        end else begin
            undervoltage_lockout_q <= undervoltage_lockout_d;
            if (pdr_s) begin
                sov_q   <= 1'b0;
                outov_q <= 1'b0;
            end else begin
                sov_q   <= sov_q | sov_s;
                outov_q <= outov_q | ov_confirm;
            end
            if (therm_clear) begin
                therm_q <= 1'b0;
            end else if (therm_done) begin
                therm_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main state machine
    wire latched_any = sov_q || therm_q || outov_q;
    // release level must be met again before leaving idle
    wire start_ok = !undervoltage_lockout_q && !latched_any && rel_s && !trip_s;
    always_comb begin
        state_d = state_q;
        case (state_q)
            PFP_IDLE: begin
                if (start_ok) begin
                    state_d = PFP_RUN;
                end
            end
            PFP_RUN: begin
                if (latched_any || sov_s) begin
                    state_d = PFP_LATCHED_OFF;
                end else if (ovl_done) begin
                    state_d = PFP_OVERLOAD_LATCH;
                end else if (undervoltage_lockout_q) begin
                    state_d = PFP_IDLE;
                end
            end
            PFP_OVERLOAD_LATCH: begin
                if (latched_any) begin
                    state_d = PFP_LATCHED_OFF;
                end else if (undervoltage_lockout_off_evt &&
                    undervoltage_lockout_cnt_q == 2'(OVERLOAD_UNDERVOLTAGE_LOCKOUT_RELEASE - 1)) begin
                    state_d = PFP_IDLE;
                end
            end
            PFP_LATCHED_OFF: begin
                if (!latched_any) begin
                    state_d = PFP_IDLE;
                end
            end
            default: begin
                state_d = PFP_IDLE;
            end
        endcase
    end

    // lockout-off events counted only while overload is latched
    always_ff @(posedge clk_in) begin
        if (rst_in || pdr_s) begin
            state_q    <= PFP_IDLE;
            undervoltage_lockout_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != PFP_OVERLOAD_LATCH) begin
                undervoltage_lockout_cnt_q <= '0;
            end else if (undervoltage_lockout_off_evt) begin
                undervoltage_lockout_cnt_q <= undervoltage_lockout_cnt_q + 2'(1);
            end
        end
    end

    // die overtemperature gates the output without latching
    logic gate_en_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gate_en_q <= 1'b0;
        end else begin
            // power-down forces the gate off before the state settles
            gate_en_q <= (state_d == PFP_RUN) && !hot_s && !sov_s
                         && !pdr_s;
        end
    end

    assign gate_enable_out       = gate_en_q;
    assign state_out             = state_q;
    assign overvoltage_guard_out = sov_q;
    assign overload_guard_out    = (state_q == PFP_OVERLOAD_LATCH);
    assign therm_latch_out       = therm_q;
    assign out_ov_latch_out      = outov_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    overload_trip_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_q == PFP_RUN && ovl_done && !latched_any && !sov_s && !pdr_s
        |=> state_q == PFP_OVERLOAD_LATCH)
        else $error("overload did not latch");
    overload_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_q == PFP_OVERLOAD_LATCH |-> !gate_en_q)
        else $error("gate on during overload latch");
    supply_ov_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sov_s |=> !gate_en_q)
        else $error("gate on after supply overvoltage");
    sov_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sov_q && !pdr_s |=> sov_q)
        else $error("supply overvoltage latch dropped");
    die_hot_a: assert property (@(posedge clk_in) disable iff (rst_in)
        hot_s |=> !gate_en_q)
        else $error("gate on while die hot");
    therm_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        therm_q && !(pdr_s && undervoltage_lockout_q) |=> therm_q)
        else $error("thermistor latch dropped");
    outov_trip_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ov_confirm && !pdr_s |=> outov_q ##1 !gate_en_q)
        else $error("output overvoltage not latched");
    pdr_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pdr_s |=> state_q == PFP_IDLE && !sov_q && !outov_q
            && !gate_en_q)
        else $error("power-down did not clear");
    latch_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        latched_any |=> !gate_en_q)
        else $error("gate on while latched");
    ovl_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_q != PFP_RUN |=> !ovl_done)
        else $error("overload timer ran outside run");
    ovl_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state_q == PFP_OVERLOAD_LATCH && !pdr_s &&
        undervoltage_lockout_cnt_q != 2'(OVERLOAD_UNDERVOLTAGE_LOCKOUT_RELEASE - 1)
        |=> state_q != PFP_IDLE)
        else $error("overload latch released early");
    ov_sample_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ov_cnt_q != $past(ov_cnt_q) && !$past(rst_in) && !$past(pdr_s)
        |-> sampled_q)
        else $error("overvoltage count moved without a sample");
    cover_run_c:   cover property (@(posedge clk_in) state_q == PFP_RUN);
    cover_olp_c:   cover property (@(posedge clk_in)
        state_q == PFP_OVERLOAD_LATCH ##1 state_q == PFP_IDLE);
    cover_outov_c: cover property (@(posedge clk_in) $rose(outov_q));
    cover_therm_c: cover property (@(posedge clk_in) $rose(therm_q));
    cover_sov_c:   cover property (@(posedge clk_in) $rose(sov_q));
endmodule : pfp_fault_fsm
`default_nettype wire

// File: pfp_pkg.sv
// constants and types shared by the pwm fault protection block
`default_nettype none
package pfp_pkg;
    localparam int unsigned CLK_MHZ        = 250;
    // overload delay in microseconds
    localparam int unsigned OVERLOAD_DLY_US = 64;
    localparam int unsigned OVERLOAD_DLY_CYC = OVERLOAD_DLY_US * CLK_MHZ;
    // thermistor pin debounce in microseconds
    localparam int unsigned THERM_DEB_US   = 300;
    localparam int unsigned THERM_DEB_CYC  = THERM_DEB_US * CLK_MHZ;
    // delay after gate turn-off before sampling, in nanoseconds
    localparam int unsigned SAMPLE_DLY_NS  = 1000;
    localparam int unsigned SAMPLE_DLY_CYC = (SAMPLE_DLY_NS + 3) / 4;
    // consecutive output overvoltage events before trip
    localparam int unsigned OUT_OV_CONFIRM = 10;
    // undervoltage-lockout off events that release the overload latch
    localparam int unsigned OVERLOAD_UNDERVOLTAGE_LOCKOUT_RELEASE = 3;

    typedef enum logic [2:0] {
        PFP_IDLE,
        PFP_RUN,
        PFP_OVERLOAD_LATCH,
        PFP_LATCHED_OFF
    } pfp_state_t;
endpackage : pfp_pkg
`default_nettype wire

// File: pfp_counter.sv
// saturating event counter with clear and terminal flag
`timescale 1ns/1ps
`default_nettype none
module pfp_counter #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned LIMIT = 10
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             clear_in,
    input  wire logic             incr_in,
    output logic                  done_out
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    // saturate at the limit so a long fault never wraps back to zero
    assign count_d = clear_in ? '0 :
                     (incr_in && count_q != LIM) ? count_q + ONE : count_q;
    assign done_out = (count_q == LIM);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule : pfp_counter
`default_nettype wire

// File: pfp_analog_model.sv
// analog comparators and gate driver facing the fault block
`timescale 1ns/1ps
`default_nettype none
module pfp_analog_model #(
    parameter int OV_MV  = 28000, // supply overvoltage trip
    parameter int PDR_MV = 6000,  // power-down reset level
    parameter int RING   = 100    // ringing cycles after turn-off
) (
    input  wire logic clk_in,
    input  var  int   vcc_mv_in,
    input  var  int   comp_mv_in,
    input  var  int   temp_c_in,
    input  var  int   ntc_mv_in,
    input  var  int   cs_mv_in,
    input  wire logic gate_enable_in,
    output logic      gate_on_out,
    output logic      cs_ov_level_out,
    output logic      overload_out,
    output logic      supply_ov_out,
    output logic      die_hot_out,
    output logic      therm_trip_out,
    output logic      therm_release_out,
    output logic      above_on_out,
    output logic      above_off_out,
    output logic      pdr_out
);
    int   pwm_q = 0;
    int   off_q = 0;
    logic hot_q = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // pwm phase, time since turn-off, die hysteresis
    always_ff @(posedge clk_in) begin
        pwm_q <= (pwm_q + 1) % 400;
        off_q <= gate_on_out ? 0 : off_q + 1;
        if (temp_c_in >= 150) hot_q <= 1'b1;
        else if (temp_c_in < 120) hot_q <= 1'b0;
    end
    // ringing reads high, so an early sample would trip falsely
    assign gate_on_out       = gate_enable_in && pwm_q < 100;
    assign cs_ov_level_out   = off_q < RING || cs_mv_in > 200;
    assign overload_out      = comp_mv_in >= 4600;
    assign supply_ov_out     = vcc_mv_in > OV_MV;
    assign die_hot_out       = hot_q;
    assign therm_trip_out    = ntc_mv_in < 1050;
    assign therm_release_out = ntc_mv_in > 950;
    assign above_on_out      = vcc_mv_in >= 16000;
    assign above_off_out     = vcc_mv_in > 7000;
    assign pdr_out           = vcc_mv_in < PDR_MV;
endmodule : pfp_analog_model
`default_nettype wire

// File: pfp_fault_fsm_bench.sv
// self-checking bench of the fault protection state machine
`timescale 1ns/1ps
`default_nettype none
module pfp_fault_fsm_bench;
    import pfp_pkg::*;
    localparam int OVL = 20;
    localparam int THM = 30;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    int vcc = 0, comp = 1000, temp = 25, ntc = 2000, cs = 100;
    int error_cnt = 0, tests_run = 0;
    logic [15:0] lfsr = 16'hDDD8;
    logic m_undervoltage_lockout = 1, m_sov = 0, m_ovl = 0, m_th = 0, m_oov = 0;
    logic m_hot = 0, m_blk = 0;
    int   m_offs = 0;
    logic gate, undervoltage_lockout, sov_l, ovl_l, th_l, oov_l, g_on, csl, ol, sov, hot;
    logic trip, rel, on_l, off_l, power_down_reset_level;
    pfp_state_t st;
    pfp_analog_model i_pfp_analog_model (.clk_in(clk_in), .vcc_mv_in(vcc),
        .comp_mv_in(comp), .temp_c_in(temp), .ntc_mv_in(ntc),
        .cs_mv_in(cs), .gate_enable_in(gate), .gate_on_out(g_on),
        .cs_ov_level_out(csl), .overload_out(ol), .supply_ov_out(sov),
        .die_hot_out(hot), .therm_trip_out(trip), .therm_release_out(rel),
        .above_on_out(on_l), .above_off_out(off_l), .pdr_out(power_down_reset_level));
    pfp_fault_fsm #(.OVERLOAD_CYC(OVL), .THERM_CYC(THM), .CNT_W(16))
    i_pfp_fault_fsm (.clk_in(clk_in), .rst_in(rst_in), .overload_in(ol),
        .supply_ov_in(sov), .die_hot_in(hot), .therm_trip_in(trip),
        .therm_release_in(rel), .cs_ov_level_in(csl), .gate_on_in(g_on),
        .vcc_above_on_in(on_l), .vcc_above_off_in(off_l),
        .power_down_reset_level_in(power_down_reset_level), .gate_enable_out(gate),
        .undervoltage_lockout_out(undervoltage_lockout), .state_out(st),
        .overvoltage_guard_out(sov_l), .overload_guard_out(ovl_l),
        .therm_latch_out(th_l), .out_ov_latch_out(oov_l));
    initial forever #2 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [5:0] g, input logic [5:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    // model outputs against the design, up to 4 cycles of latency plus margin
    task automatic chk;
        cmp({gate, undervoltage_lockout, sov_l, ovl_l, th_l, oov_l},
            {!(m_undervoltage_lockout | m_sov | m_ovl | m_th | m_oov | m_hot | m_blk),
             m_undervoltage_lockout, m_sov, m_ovl, m_th, m_oov});
    endtask : chk
    // supply model: lockout, off events, power-down clearing
    task automatic set_vcc(input int v);
        if (v > 28000) m_sov = 1;
        if (v >= 16000 && m_undervoltage_lockout) m_blk = ntc <= 950;
        if (v >= 16000) m_undervoltage_lockout = 0;
        if (v <= 7000 && vcc > 7000 && m_ovl) m_offs++;
        if (m_offs == 3) {m_ovl, m_offs} = 0;
        if (v <= 7000) m_undervoltage_lockout = 1;
        if (v < 6000) {m_sov, m_oov, m_th} = 0;
        vcc = v;
        cyc(5);
        chk();
    endtask : set_vcc
    // n turn-off edges, then past the sample point of the last
    task automatic pulses(input int n);
        int k;
        logic d;
        k = 0;
        d = g_on;
        while (n > 0 && k < 5000) begin
            cyc(1);
            k++;
            if (d && !g_on) n--;
            d = g_on;
        end
        if (n > 0) begin
            error_cnt++;
            print_verdict();
        end
        cyc(300);
    endtask : pulses
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(10);
        rst_in = 0;
        cyc(4);
        chk();
        set_vcc(17000);
        // random short overload bursts never add up to a trip
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            comp = 4700;
            cyc(1 + lfsr % 12);
            comp = 1000;
            cyc(3);
        end
        chk();
        comp = 4700;
        cyc(OVL + 6);
        m_ovl = 1;
        chk();
        comp = 1000;
        for (int i = 0; i < 3; i++) begin
            set_vcc(7000);
            set_vcc(17000);
        end
        temp = 160;
        cyc(6);
        m_hot = 1;
        chk();
        temp = 130;
        cyc(6);
        chk();
        temp = 100;
        cyc(6);
        m_hot = 0;
        chk();
        set_vcc(31000);
        set_vcc(17000);
        set_vcc(7000);
        set_vcc(5000);
        set_vcc(17000);
        ntc = 900;
        cyc(15);
        chk();
        cyc(25);
        m_th = 1;
        chk();
        set_vcc(7000);
        set_vcc(5000);
        set_vcc(17000);
        cyc(40);
        m_th = 1;
        chk();
        ntc = 2000;
        set_vcc(7000);
        set_vcc(5000);
        set_vcc(17000);
        cs = 300;
        pulses(9);
        chk();
        cs = 100;
        pulses(1);
        cs = 300;
        pulses(9);
        chk();
        pulses(1);
        m_oov = 1;
        chk();
        cs = 100;
        set_vcc(17000);
        set_vcc(7000);
        set_vcc(5000);
        set_vcc(17000);
        rst_in = 1;
        cyc(10);
        m_undervoltage_lockout = 1;
        chk();
        cmp({3'b000, st}, {3'b000, PFP_IDLE});
        rst_in = 0;
        set_vcc(7000);
        set_vcc(17000);
        set_vcc(7000);
        set_vcc(17000);
        set_vcc(5000);
        print_verdict();
    end
endmodule : pfp_fault_fsm_bench
`default_nettype wire
